// ==== rtl/dmpp_consts.svh ====
// offsets, field positions, reset values and timing counts of the mode-page store
`ifndef DMPP_CONSTS_SVH
`define DMPP_CONSTS_SVH

// page codes
`define DMPP_PG_CACHE 6'h08
`define DMPP_PG_ZONE 6'h0C
`define DMPP_PG_IDLE 6'h32
`define DMPP_PG_CTRL 6'h37

// page lengths as reported in byte 1
`define DMPP_LEN_CACHE 8'h0A
`define DMPP_LEN_ZONE 8'h16
`define DMPP_LEN_IDLE 8'h02
`define DMPP_LEN_CTRL 8'h0E

// byte offsets within pages
`define DMPP_B_CODE 5'h00
`define DMPP_B_LEN 5'h01
`define DMPP_B_FLAGS 5'h02
`define DMPP_B_CTRL_SEG 5'h03
`define DMPP_B_CTRL_MINPF 5'h04
`define DMPP_B_CTRL_MAXPF 5'h05
`define DMPP_B_CACHE_MINPF 5'h07
`define DMPP_B_CACHE_MAXPF 5'h09
`define DMPP_B_ZONE_MAX_HI 5'h04
`define DMPP_B_ZONE_MAX_LO 5'h05
`define DMPP_B_ZONE_ACT_HI 5'h06
`define DMPP_B_ZONE_ACT_LO 5'h07
`define DMPP_B_ZONE_START 5'h08
`define DMPP_B_ZONE_END 5'h0C
`define DMPP_B_ZONE_MAP 5'h10
`define DMPP_B_ZONE_LAST 5'h17
`define DMPP_B_IDLE_STBY 5'h02
`define DMPP_B_IDLE_SHDN 5'h03

// flag bit positions
`define DMPP_BIT_SAVEABLE 7
`define DMPP_BIT_ZONED 7
`define DMPP_BIT_BKIND 6
`define DMPP_BIT_KEEP_SYNC 5
`define DMPP_BIT_ORIG_SYNC 4
`define DMPP_BIT_WIDX 3
`define DMPP_BIT_PF_ONLY 2
`define DMPP_BIT_PF_EN 1
`define DMPP_BIT_CACHE_EN 0
`define DMPP_BIT_WCE 2
`define DMPP_BIT_RCD 0

// fixed zone-page values
`define DMPP_ZONE_COUNT 16'h0010
`define DMPP_ZONE_LAST_IDX 4'hF
`define DMPP_ZONE_MAP 64'h0000_0000_0000_1008
`define DMPP_ZONE_START_HEAD 8'h00
`define DMPP_ZONE_END_HEAD 8'h00
`define DMPP_UNIT_LAST_CYL 24'd2852

// reset values
`define DMPP_RST_PF_EN 1'b1
`define DMPP_RST_CACHE_EN 1'b1
`define DMPP_RST_WCE 1'b1
`define DMPP_RST_MINUTES 8'h00

// timing: one minute of seconds, one second of clock cycles
`define DMPP_CLK_HZ 100000000
`define DMPP_MINUTE_S 60
`define DMPP_SEC_CYCLES (`DMPP_CLK_HZ * 1)

`endif

// ==== rtl/dmpp_idle_timer.sv ====
// minute timer that expires after a condition has held for a set number of minutes
`timescale 1ns/1ps
`include "dmpp_consts.svh"

module dmpp_idle_timer #(
  parameter logic [7:0] SEC_PER_MIN = 8'(`DMPP_MINUTE_S)
) (
  input wire logic clk,          // system clock
  input wire logic rstn,         // async reset, active low
  input wire logic active,       // condition being timed
  input wire logic sec_tick,     // one-cycle pulse per second
  input wire logic [7:0] limit,  // minutes, zero disables
  output logic expired           // condition held for limit minutes
);

  dmpp_pkg::dmpp_idle_t state;
  dmpp_pkg::dmpp_idle_t next_state;
  logic [7:0] sec_cnt;
  logic [7:0] min_cnt;
  logic active_q;

  // ------------------------------------------------------------------
  // phase decode
  // ------------------------------------------------------------------
  // a change of condition or a zero limit drops back to off, so the count restarts
  wire restart = (active != active_q) || !active || (limit == 8'h00);
  wire min_wrap = sec_tick && (sec_cnt == SEC_PER_MIN - 8'h01);
  // a limit lowered below the running count expires at once instead of waiting for wrap
  wire reached = (min_cnt >= limit);

  always_comb begin
    next_state = state;
    unique case (state)
      dmpp_pkg::DMPP_IDLE_OFF: next_state = restart ? dmpp_pkg::DMPP_IDLE_OFF
                                                    : dmpp_pkg::DMPP_IDLE_RUN;
      dmpp_pkg::DMPP_IDLE_RUN: next_state = restart ? dmpp_pkg::DMPP_IDLE_OFF
                                          : (reached ? dmpp_pkg::DMPP_IDLE_HIT
                                                     : dmpp_pkg::DMPP_IDLE_RUN);
      dmpp_pkg::DMPP_IDLE_HIT: next_state = restart ? dmpp_pkg::DMPP_IDLE_OFF
                                                    : dmpp_pkg::DMPP_IDLE_HIT;
      default: next_state = dmpp_pkg::DMPP_IDLE_OFF;
    endcase
  end

  // ------------------------------------------------------------------
  // counters
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= dmpp_pkg::DMPP_IDLE_OFF;
      active_q <= 1'b0;
      sec_cnt <= 8'h00;
      min_cnt <= 8'h00;
    end else begin
      state <= next_state;
      active_q <= active;
      if (next_state != dmpp_pkg::DMPP_IDLE_RUN) begin
        sec_cnt <= 8'h00;
        min_cnt <= 8'h00;
      end else if (min_wrap) begin
        sec_cnt <= 8'h00;
        min_cnt <= min_cnt + 8'h01;
      end else if (sec_tick) begin
        sec_cnt <= sec_cnt + 8'h01;
      end
    end
  end

  assign expired = (state == dmpp_pkg::DMPP_IDLE_HIT);

endmodule // dmpp_idle_timer

// ==== rtl/dmpp_mode_pages.sv ====
// mode-page store for the zone, idle-time and cache-control pages
`timescale 1ns/1ps
`include "dmpp_consts.svh"

module dmpp_mode_pages #(
  parameter int SEC_CYCLES = `DMPP_SEC_CYCLES,       // clock cycles per second
  parameter logic [7:0] SEC_PER_MIN = 8'(`DMPP_MINUTE_S) // seconds per minute
) (
  input wire logic clk,                      // system clock, 100 MHz
  input wire logic rstn,                     // async reset, active low
  input wire logic wr_en,                    // page byte write strobe
  input wire dmpp_pkg::dmpp_acc_t wr_acc,    // page, byte and data written
  input wire logic rd_en,                    // page byte read strobe
  input wire dmpp_pkg::dmpp_acc_t rd_acc,    // page and byte read, data unused
  input wire logic selected,                 // drive currently selected
  input wire logic drive_reset,              // drive reset event, one cycle
  input wire logic [7:0] seg_count,          // cache segments from cache engine
  input wire logic [7:0] min_prefetch,       // minimum prefetch from cache engine
  input wire logic [7:0] max_prefetch,       // maximum prefetch from cache engine
  output logic [7:0] rd_data,                // byte read, one cycle after rd_en
  output logic rd_valid,                     // rd_data valid pulse
  output logic wr_error,                     // rejected active-zone write pulse
  output logic [3:0] active_zone,            // zone later accesses refer to
  output dmpp_pkg::dmpp_cache_t cache_ctl,   // cache and sync controls
  output logic standby,                      // standby mode request
  output logic shutdown,                     // power-shutdown request
  output logic sync_table_clear              // clear per-initiator sync table pulse
);

  // ------------------------------------------------------------------
  // stored fields
  // ------------------------------------------------------------------
  logic [7:0] standby_min;
  logic [7:0] shutdown_min;
  logic keep_sync_table_flag;
  logic originate_sync_request_flag;
  logic write_index_flag;
  logic prefetch_only_flag;
  logic prefetch_enable_flag;
  logic cache_enable_flag;
  logic write_cache_flag;
  logic [31:0] sec_cnt;
  logic sec_tick;
  logic standby_hit;
  logic shutdown_hit;

  // ------------------------------------------------------------------
  // zone boundary table
  // ------------------------------------------------------------------
  // fixed per-zone cylinders; a small constant table costs less than a rom
  function automatic logic [23:0] zone_start(input logic [3:0] z);
    logic [23:0] c;
    c = 24'd0;
    unique case (z)
      4'h0: c = 24'd0;
      4'h1: c = 24'd200;
      4'h2: c = 24'd359;
      4'h3: c = 24'd597;
      4'h4: c = 24'd745;
      4'h5: c = 24'd873;
      4'h6: c = 24'd1031;
      4'h7: c = 24'd1219;
      4'h8: c = 24'd1397;
      4'h9: c = 24'd1585;
      4'hA: c = 24'd1783;
      4'hB: c = 24'd1941;
      4'hC: c = 24'd2179;
      4'hD: c = 24'd2297;
      4'hE: c = 24'd2435;
      4'hF: c = 24'd2613;
    endcase
    return c;
  endfunction

  function automatic logic [23:0] zone_end(input logic [3:0] z);
    logic [23:0] c;
    c = 24'd0;
    unique case (z)
      4'h0: c = 24'd199;
      4'h1: c = 24'd358;
      4'h2: c = 24'd596;
      4'h3: c = 24'd744;
      4'h4: c = 24'd872;
      4'h5: c = 24'd1030;
      4'h6: c = 24'd1218;
      4'h7: c = 24'd1396;
      4'h8: c = 24'd1586;
      4'h9: c = 24'd1782;
      4'hA: c = 24'd1940;
      4'hB: c = 24'd2178;
      4'hC: c = 24'd2296;
      4'hD: c = 24'd2434;
      4'hE: c = 24'd2612;
      4'hF: c = 24'd2852;
    endcase
    return c;
  endfunction

  // zone zero stands for the whole unit, so it spans first to last cylinder
  wire [23:0] start_cyl = (active_zone == 4'h0) ? 24'd0 : zone_start(active_zone);
  wire [23:0] end_cyl = (active_zone == 4'h0) ? `DMPP_UNIT_LAST_CYL
                                              : zone_end(active_zone);
  wire [31:0] start_bnd = {start_cyl, `DMPP_ZONE_START_HEAD};
  wire [31:0] end_bnd = {end_cyl, `DMPP_ZONE_END_HEAD};
  wire [63:0] zone_map = `DMPP_ZONE_MAP;
  wire [15:0] zone_count = `DMPP_ZONE_COUNT;

  // ------------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------------
  wire wr_zone = wr_en && (wr_acc.page == `DMPP_PG_ZONE);
  wire wr_idle = wr_en && (wr_acc.page == `DMPP_PG_IDLE);
  wire wr_ctrl_flags = wr_en && (wr_acc.page == `DMPP_PG_CTRL) &&
                       (wr_acc.idx == `DMPP_B_FLAGS);
  wire wr_cache_flags = wr_en && (wr_acc.page == `DMPP_PG_CACHE) &&
                        (wr_acc.idx == `DMPP_B_FLAGS);
  // high byte of the zone number must be zero and low byte at most fifteen
  wire wr_zone_hi = wr_zone && (wr_acc.idx == `DMPP_B_ZONE_ACT_HI);
  wire wr_zone_lo = wr_zone && (wr_acc.idx == `DMPP_B_ZONE_ACT_LO);
  wire zone_ok = (wr_acc.data[7:4] == 4'h0);
  wire zone_take = wr_zone_lo && zone_ok;
  wire zone_bad = (wr_zone_lo && !zone_ok) ||
                  (wr_zone_hi && (wr_acc.data != 8'h00));
  wire rcd_bit = wr_acc.data[`DMPP_BIT_RCD];

  // active zone, changed only by a valid write to its own field
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_zone <= 4'h0;
      wr_error <= 1'b0;
    end else begin
      wr_error <= zone_bad;
      if (zone_take) begin
        active_zone <= wr_acc.data[3:0];
      end
    end
  end

  // idle-time minute limits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      standby_min <= `DMPP_RST_MINUTES;
      shutdown_min <= `DMPP_RST_MINUTES;
    end else if (wr_idle && (wr_acc.idx == `DMPP_B_IDLE_STBY)) begin
      standby_min <= wr_acc.data;
    end else if (wr_idle && (wr_acc.idx == `DMPP_B_IDLE_SHDN)) begin
      shutdown_min <= wr_acc.data;
    end
  end

  // cache flags: one store serves both pages so they always mirror
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      keep_sync_table_flag <= 1'b0;
      originate_sync_request_flag <= 1'b0;
      write_index_flag <= 1'b0;
      prefetch_only_flag <= 1'b0;
      prefetch_enable_flag <= `DMPP_RST_PF_EN;
      cache_enable_flag <= `DMPP_RST_CACHE_EN;
      write_cache_flag <= `DMPP_RST_WCE;
    end else if (wr_ctrl_flags) begin
      keep_sync_table_flag <= wr_acc.data[`DMPP_BIT_KEEP_SYNC];
      originate_sync_request_flag <= wr_acc.data[`DMPP_BIT_ORIG_SYNC];
      write_index_flag <= wr_acc.data[`DMPP_BIT_WIDX];
      prefetch_only_flag <= wr_acc.data[`DMPP_BIT_PF_ONLY];
      prefetch_enable_flag <= wr_acc.data[`DMPP_BIT_PF_EN];
      cache_enable_flag <= wr_acc.data[`DMPP_BIT_CACHE_EN];
    end else if (wr_cache_flags) begin
      write_cache_flag <= wr_acc.data[`DMPP_BIT_WCE];
      prefetch_enable_flag <= !rcd_bit;
      cache_enable_flag <= !rcd_bit;
    end
  end

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  // read-cache-disable is the mirror of cache enable on the cache page
  wire rcd_view = !cache_enable_flag;
  wire [7:0] ctrl_flags = {2'b00, keep_sync_table_flag, originate_sync_request_flag,
                           write_index_flag, prefetch_only_flag, prefetch_enable_flag,
                           cache_enable_flag};
  wire [7:0] cache_flags = {5'b00000, write_cache_flag, 1'b0, rcd_view};
  // zone page byte 2: zoned set, boundary kind clear, rest reserved
  wire [7:0] zone_flags = 8'h80;
  wire [4:0] ri = rd_acc.idx;
  wire [4:0] map_off = ri - `DMPP_B_ZONE_MAP;
  wire [2:0] map_byte = 3'd7 - map_off[2:0];
  wire [1:0] bnd_byte = 2'd3 - ri[1:0];

  logic [7:0] next_rd_data;
  always_comb begin
    next_rd_data = 8'h00;
    unique case (rd_acc.page)
      `DMPP_PG_ZONE: begin
        if (ri == `DMPP_B_CODE) begin
          next_rd_data = {1'b0, 1'b0, `DMPP_PG_ZONE};
        end else if (ri == `DMPP_B_LEN) begin
          next_rd_data = `DMPP_LEN_ZONE;
        end else if (ri == `DMPP_B_FLAGS) begin
          next_rd_data = zone_flags;
        end else if (ri == `DMPP_B_ZONE_MAX_HI) begin
          next_rd_data = zone_count[15:8];
        end else if (ri == `DMPP_B_ZONE_MAX_LO) begin
          next_rd_data = zone_count[7:0];
        end else if (ri == `DMPP_B_ZONE_ACT_LO) begin
          next_rd_data = {4'h0, active_zone};
        end else if (ri >= `DMPP_B_ZONE_START && ri < `DMPP_B_ZONE_END) begin
          next_rd_data = start_bnd[bnd_byte*8 +: 8];
        end else if (ri >= `DMPP_B_ZONE_END && ri < `DMPP_B_ZONE_MAP) begin
          next_rd_data = end_bnd[bnd_byte*8 +: 8];
        end else if (ri >= `DMPP_B_ZONE_MAP && ri <= `DMPP_B_ZONE_LAST) begin
          next_rd_data = zone_map[map_byte*8 +: 8];
        end
      end
      `DMPP_PG_IDLE: begin
        if (ri == `DMPP_B_CODE) begin
          next_rd_data = {2'b00, `DMPP_PG_IDLE};
        end else if (ri == `DMPP_B_LEN) begin
          next_rd_data = `DMPP_LEN_IDLE;
        end else if (ri == `DMPP_B_IDLE_STBY) begin
          next_rd_data = standby_min;
        end else if (ri == `DMPP_B_IDLE_SHDN) begin
          next_rd_data = shutdown_min;
        end
      end
      `DMPP_PG_CTRL: begin
        if (ri == `DMPP_B_CODE) begin
          next_rd_data = {2'b00, `DMPP_PG_CTRL};
        end else if (ri == `DMPP_B_LEN) begin
          next_rd_data = `DMPP_LEN_CTRL;
        end else if (ri == `DMPP_B_FLAGS) begin
          next_rd_data = ctrl_flags;
        end else if (ri == `DMPP_B_CTRL_SEG) begin
          next_rd_data = seg_count;
        end else if (ri == `DMPP_B_CTRL_MINPF) begin
          next_rd_data = min_prefetch;
        end else if (ri == `DMPP_B_CTRL_MAXPF) begin
          next_rd_data = max_prefetch;
        end
      end
      `DMPP_PG_CACHE: begin
        if (ri == `DMPP_B_CODE) begin
          next_rd_data = {2'b00, `DMPP_PG_CACHE};
        end else if (ri == `DMPP_B_LEN) begin
          next_rd_data = `DMPP_LEN_CACHE;
        end else if (ri == `DMPP_B_FLAGS) begin
          next_rd_data = cache_flags;
        end else if (ri == `DMPP_B_CACHE_MINPF) begin
          next_rd_data = min_prefetch;
        end else if (ri == `DMPP_B_CACHE_MAXPF) begin
          next_rd_data = max_prefetch;
        end
      end
      default: next_rd_data = 8'h00;
    endcase
  end

  // read data registered, valid one cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= next_rd_data;
      end
    end
  end

  // ------------------------------------------------------------------
  // controls to the drive
  // ------------------------------------------------------------------
  // prefetch is gated here so the cache engine never sees it without the cache
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cache_ctl <= '0;
      sync_table_clear <= 1'b0;
    end else begin
      cache_ctl.keep_sync <= keep_sync_table_flag;
      cache_ctl.originate_sync <= originate_sync_request_flag;
      cache_ctl.prefetch <= prefetch_enable_flag && cache_enable_flag;
      cache_ctl.cache_on <= cache_enable_flag;
      cache_ctl.write_cache <= write_cache_flag;
      sync_table_clear <= drive_reset && !keep_sync_table_flag;
    end
  end

  // ------------------------------------------------------------------
  // idle timers
  // ------------------------------------------------------------------
  // one-second prescaler shared by both timers keeps each timer narrow
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sec_cnt <= 32'h0000_0000;
      sec_tick <= 1'b0;
    end else if (sec_cnt == 32'(SEC_CYCLES - 1)) begin
      sec_cnt <= 32'h0000_0000;
      sec_tick <= 1'b1;
    end else begin
      sec_cnt <= sec_cnt + 32'h0000_0001;
      sec_tick <= 1'b0;
    end
  end

  dmpp_idle_timer #(.SEC_PER_MIN(SEC_PER_MIN)) u_standby (
    .clk(clk),
    .rstn(rstn),
    .active(selected),
    .sec_tick(sec_tick),
    .limit(standby_min),
    .expired(standby_hit)
  );

  dmpp_idle_timer #(.SEC_PER_MIN(SEC_PER_MIN)) u_shutdown (
    .clk(clk),
    .rstn(rstn),
    .active(!selected),
    .sec_tick(sec_tick),
    .limit(shutdown_min),
    .expired(shutdown_hit)
  );

  assign standby = standby_hit;
  assign shutdown = shutdown_hit;

endmodule // dmpp_mode_pages

// ==== rtl/dmpp_pkg.sv ====
// types shared by the mode-page store
package dmpp_pkg;

  // one byte access to a mode page
  typedef struct packed {
    logic [5:0] page;
    logic [4:0] idx;
    logic [7:0] data;
  } dmpp_acc_t;

  // cache and negotiation controls driven to the rest of the drive
  typedef struct packed {
    logic keep_sync;
    logic originate_sync;
    logic prefetch;
    logic cache_on;
    logic write_cache;
  } dmpp_cache_t;

  // idle timer phase
  typedef enum logic [1:0] {
    DMPP_IDLE_OFF = 2'b00,
    DMPP_IDLE_RUN = 2'b01,
    DMPP_IDLE_HIT = 2'b10
  } dmpp_idle_t;

endpackage

// ==== verification/dmpp_initiator.sv ====
// initiator model: byte-wide mode select and mode sense transfers
`timescale 1ns/1ps
module dmpp_initiator (
  input wire logic clk, // clock
  input wire logic rd_valid, // read pulse
  input wire logic [7:0] rd_data, // byte read
  input wire logic wr_error, // refused write
  output logic wr_en, // write strobe
  output dmpp_pkg::dmpp_acc_t wr_acc, // write access
  output logic rd_en, // read strobe
  output dmpp_pkg::dmpp_acc_t rd_acc // read access
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_acc = '0;
    rd_acc = '0;
  end
  // one strobe cycle; released fields flip so no stale value looks valid
  task automatic put(input logic [5:0] p, input logic [4:0] i, input logic [7:0] d,
                     output logic err);
    @(negedge clk);
    wr_acc = '{p, i, d};
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    wr_acc = ~wr_acc;
    err = wr_error;
  endtask
  task automatic get(input logic [5:0] p, input logic [4:0] i, output logic v,
                     output logic [7:0] d);
    @(negedge clk);
    rd_acc = '{p, i, 8'h00};
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    rd_acc = ~rd_acc;
    v = rd_valid;
    d = rd_data;
  endtask
endmodule // dmpp_initiator

// ==== verification/dmpp_mode_pages_tb.sv ====
// testbench: mode-page store against a behavioural page model
`timescale 1ns/1ps
module dmpp_mode_pages_tb;
  logic clk, rstn, wr_en, rd_en, selected, drive_reset, rd_valid, wr_error;
  logic standby, shutdown, sync_table_clear, wce;
  dmpp_pkg::dmpp_acc_t wr_acc, rd_acc;
  dmpp_pkg::dmpp_cache_t cache_ctl;
  logic [7:0] seg_count, min_prefetch, max_prefetch, rd_data, fl, stby, shdn;
  logic [3:0] active_zone;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int az = 0;
  int seed = 32'hbdff3f36;
  int zs[16] = '{0, 200, 359, 597, 745, 873, 1031, 1219, 1397, 1585, 1783, 1941, 2179,
                 2297, 2435, 2613};
  int ze[16] = '{199, 358, 596, 744, 872, 1030, 1218, 1396, 1586, 1782, 1940, 2178, 2296,
                 2434, 2612, 2852};
  // short counts keep a minute at 30 cycles
  dmpp_mode_pages #(.SEC_CYCLES(10), .SEC_PER_MIN(8'h03)) dut (.clk(clk), .rstn(rstn),
    .wr_en(wr_en), .wr_acc(wr_acc), .rd_en(rd_en), .rd_acc(rd_acc), .selected(selected),
    .drive_reset(drive_reset), .seg_count(seg_count), .min_prefetch(min_prefetch),
    .max_prefetch(max_prefetch), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_error(wr_error), .active_zone(active_zone), .cache_ctl(cache_ctl),
    .standby(standby), .shutdown(shutdown), .sync_table_clear(sync_table_clear));
  dmpp_initiator ini (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
    .wr_error(wr_error), .wr_en(wr_en), .wr_acc(wr_acc), .rd_en(rd_en), .rd_acc(rd_acc));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, the run needs about 4500 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end
  // ----
  // model and compare helpers
  // ----
  function automatic logic [7:0] exp_b(input logic [5:0] p, input logic [4:0] i);
    logic [191:0] m;
    case (p)
      6'h0C: m = {32'h0C168000, 16'h0010, 12'h000, 4'(az), 24'(zs[az]), 8'h00,
                  24'(az == 0 ? ze[15] : ze[az]), 8'h00, 64'h0000_0000_0000_1008};
      6'h32: m = {16'h3202, stby, shdn, 160'h0};
      6'h37: m = {16'h370E, fl, seg_count, min_prefetch, max_prefetch, 144'h0};
      6'h08: m = {16'h080A, 5'h00, wce, 1'b0, ~fl[0], 32'h0, min_prefetch, 8'h00,
                  max_prefetch, 112'h0};
      default: m = '0;
    endcase
    return m[(23 - i) * 8 +: 8];
  endfunction
  function automatic logic [7:0] ctl_x();
    return {3'h0, fl[5], fl[4], fl[1] & fl[0], fl[0], wce};
  endfunction
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [5:0] p, input logic [4:0] i);
    logic v;
    logic [7:0] d;
    ini.get(p, i, v, d);
    cmp("rd_valid", 8'h01, 8'(v));
    cmp($sformatf("page %h byte %0d", p, i), exp_b(p, i), d);
  endtask
  // all 24 bytes of every page and of one unmapped page
  task automatic dump();
    logic [5:0] pg[5] = '{6'h0C, 6'h32, 6'h37, 6'h08, 6'h3F};
    for (int p = 0; p < 5; p++) begin
      for (int i = 0; i < 24; i++) begin
        rdc(pg[p], 5'(i));
      end
    end
  endtask
  task automatic wait_lvl(input bit sh, output int n);
    n = 0;
    while ((sh ? shutdown : standby) !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic close_out();
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    logic err;
    logic [7:0] d;
    int n;
    rstn = 1'b0;
    selected = 1'b0;
    drive_reset = 1'b0;
    {seg_count, min_prefetch, max_prefetch} = 24'($random(seed));
    fl = 8'h03;
    wce = 1'b1;
    stby = 8'h00;
    shdn = 8'h00;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    dump();
    cmp("cache_ctl", ctl_x(), 8'(cache_ctl));
    // zones top down so the return to zero follows real zones
    for (int z = 15; z >= 0; z--) begin
      ini.put(6'h0C, 5'h07, 8'(z), err);
      cmp("wr_error", 8'h00, 8'(err));
      az = z;
      cmp("active_zone", 8'(z), 8'(active_zone));
      d = 8'($random(seed));
      ini.put(6'h0C, 5'(8 + z), d, err);
      ini.put(6'h0C, 5'h07, d | 8'h10, err);
      cmp("wr_error", 8'h01, 8'(err));
      ini.put(6'h0C, 5'h06, d | 8'h01, err);
      cmp("wr_error", 8'h01, 8'(err));
      ini.put(6'h37, 5'h03, d, err);
      {seg_count, min_prefetch, max_prefetch} = 24'($random(seed));
      dump();
    end
    // flags through both pages, disable bit alternating
    for (int k = 0; k < 8; k++) begin
      d = 8'($random(seed));
      if (k[0]) begin
        // cleared enables let the next cache-page write show the set
        if (k[1]) begin
          d[1:0] = 2'b00;
        end
        ini.put(6'h37, 5'h02, d, err);
        fl = d & 8'h3F;
      end else begin
        d[0] = k[1];
        ini.put(6'h08, 5'h02, d, err);
        fl[1:0] = d[0] ? 2'b00 : 2'b11;
        wce = d[2];
      end
      rdc(6'h37, 5'h02);
      rdc(6'h08, 5'h02);
      cmp("cache_ctl", ctl_x(), 8'(cache_ctl));
    end
    ini.put(6'h32, 5'h02, 8'h02, err);
    ini.put(6'h32, 5'h03, 8'h01, err);
    stby = 8'h02;
    shdn = 8'h01;
    rdc(6'h32, 5'h02);
    rdc(6'h32, 5'h03);
    selected = 1'b1;
    wait_lvl(1'b0, n);
    cmp("standby_time", 8'h01, 8'(n >= 45 && n <= 80));
    cmp("shutdown", 8'h00, 8'(shutdown));
    selected = 1'b0;
    wait_lvl(1'b1, n);
    cmp("shutdown_time", 8'h01, 8'(n >= 20 && n <= 50));
    cmp("standby", 8'h00, 8'(standby));
    ini.put(6'h32, 5'h03, 8'h00, err);
    repeat (40) @(negedge clk);
    cmp("shutdown", 8'h00, 8'(shutdown));
    // reset event with the keep flag off, then on
    for (int k = 0; k < 2; k++) begin
      ini.put(6'h37, 5'h02, {2'b00, k[0], 5'h03}, err);
      @(negedge clk);
      drive_reset = 1'b1;
      @(negedge clk);
      drive_reset = 1'b0;
      cmp("sync_table_clear", 8'(!k[0]), 8'(sync_table_clear));
    end
    close_out();
  end
endmodule // dmpp_mode_pages_tb
bind dmpp_mode_pages dmpp_mode_pages_chk u_chk (.clk(clk), .rstn(rstn), .wr_en(wr_en),
  .wr_acc(wr_acc), .rd_en(rd_en), .rd_acc(rd_acc), .selected(selected),
  .drive_reset(drive_reset), .rd_data(rd_data), .rd_valid(rd_valid), .wr_error(wr_error),
  .active_zone(active_zone), .cache_ctl(cache_ctl), .standby(standby),
  .sync_table_clear(sync_table_clear));

// ==== verification/dmpp_properties.sv ====
// checker: port-level assertions on the mode-page store
`timescale 1ns/1ps
module dmpp_mode_pages_chk (
  input wire logic clk, // clock
  input wire logic rstn, // reset
  input wire logic wr_en, // write
  input wire dmpp_pkg::dmpp_acc_t wr_acc, // write access
  input wire logic rd_en, // read
  input wire dmpp_pkg::dmpp_acc_t rd_acc, // read access
  input wire logic selected, // selected
  input wire logic drive_reset, // reset event
  input wire logic [7:0] rd_data, // byte read
  input wire logic rd_valid, // read pulse
  input wire logic wr_error, // refused write
  input wire logic [3:0] active_zone, // zone
  input wire dmpp_pkg::dmpp_cache_t cache_ctl, // controls
  input wire logic standby, // standby
  input wire logic sync_table_clear // sync clear
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----
  // zone page accesses
  // ----
  logic zr;
  logic zw;
  assign zr = rd_en && rd_acc.page == 6'h0C;
  assign zw = wr_en && wr_acc.page == 6'h0C;
  sequence s_byte(logic [7:0] v);
    rd_valid && rd_data == v;
  endsequence
  chk_zone_code: assert property (zr && rd_acc.idx == 5'h00 |=> s_byte(8'h0C))
    else $error("zone code byte wrong");
  chk_zone_flags: assert property (zr && rd_acc.idx == 5'h02 |=> s_byte(8'h80))
    else $error("zone flags byte wrong");
  chk_zone_max: assert property (zr && rd_acc.idx == 5'h05 |=> s_byte(8'h10))
    else $error("zone count wrong");
  chk_zone_map: assert property (zr && rd_acc.idx == 5'h17 |=> s_byte(8'h08))
    else $error("zone map low byte wrong");
  chk_zone_ro: assert property (zw && wr_acc.idx > 5'h07 |=> $stable(active_zone))
    else $error("read-only zone byte took a write");
  chk_zone_bad: assert property (zw && wr_acc.idx == 5'h07 && wr_acc.data > 8'h0F
    |=> wr_error && $stable(active_zone)) else $error("bad zone not refused");
  // cache controls: prefetch needs cache, disable clears both a cycle late
  chk_pf_gate: assert property (cache_ctl.prefetch |-> cache_ctl.cache_on)
    else $error("prefetch without cache");
  chk_rcd_clr: assert property (wr_en && wr_acc.page == 6'h08 && wr_acc.idx == 5'h02
    && wr_acc.data[0] |=> ##1 !cache_ctl.cache_on && !cache_ctl.prefetch)
    else $error("cache disable ignored");
  chk_stby_drop: assert property ($fell(selected) |-> ##[1:2] !standby)
    else $error("standby kept after deselect");
  chk_sync_clr: assert property (drive_reset
    |=> sync_table_clear == !$past(cache_ctl.keep_sync)) else $error("sync clear wrong");
endmodule // dmpp_mode_pages_chk
